/* hdl/tcs_bank.sv */
// Timer count bytes, clock and stretch control, port one latch and clock status registers behind APB.
// Assumes a single pclk domain; timer run levels, moves and interrupt edges come from core logic on pclk.
`timescale 1ns/1ps
`include "tcs_map.svh"

// Functional notes
// - Timer 0 high count byte is a read/write register at its own index and resets to zero.
// - Timer 1 high count byte is a read/write register at its own index and resets to zero.
// - An external data move holds its read or write strobe longer by the interval the stretch field selects.
// - A data move to internal memory always takes two machine cycles regardless of the stretch field.
// - Stretch values 0 to 3 give 2 to 5 machine cycles, 4 to 7 give 9 to 12, and reset value 1 gives 3.
// - The resume clock select bit clears only on power-on reset and keeps its value over any other reset.
// - With resume clock select clear the core stays halted after Stop until the crystal has warmed up.
// - With resume clock select set the core resumes at once on the ring oscillator and moves to the crystal later.
// - Without a ring oscillator (HAS_RING clear) the resume clock select bit stays clear, so the core always waits for the crystal after Stop.
// - With band-gap select clear the reference is off in Stop but on in normal running; set keeps it on in Stop.
// - While the reference is off in Stop no power-fail interrupt or reset can be raised.
// - The band-gap select bit clears on presetn and otherwise changes only on a write that directly follows the timed access unlock sequence.
module tcs_bank #(
    parameter int MC_CLKS = `TCS_MC_CLKS,
    parameter bit HAS_RING = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer0_run,
    input wire logic timer1_run,
    input wire logic [3:0] ext_int_set,
    input wire logic move_start,
    input wire logic move_external,
    input wire logic move_read,
    input wire logic stop_req,
    input wire logic wake_evt,
    input wire logic crystal_warm,
    output logic timer0_overflow,
    output logic timer1_overflow,
    output logic timer2_clock_select,
    output logic [7:0] port_one_latch,
    output logic move_busy,
    output logic ext_rd_strobe,
    output logic ext_wr_strobe,
    output logic move_done,
    output logic core_halt,
    output logic run_on_ring,
    output logic bandgap_en,
    output logic powerfail_en
);

    typedef struct packed {
        logic [7:0] timer0_low_byte;
        logic [7:0] timer0_high_byte;
        logic [7:0] timer1_low_byte;
        logic [7:0] timer1_high_byte;
        logic [7:0] clock_and_stretch_control;
        logic [7:0] port_one;
        logic [3:0] int_flags;
        logic bandgap_stop_select;
        logic [3:0] pre0;
        logic [3:0] pre1;
        logic ta_first;
        logic ta_armed;
        logic ovf0;
        logic ovf1;
        logic rdy;
        logic err;
        logic [31:0] rdata;
    } tcs_bank_t;

    tcs_bank_t s_r;
    tcs_bank_t s_nxt;
    logic resume_clock_select;
    logic access;
    logic setup_done;
    logic wr_acc;
    logic [7:0] idx;
    logic [7:0] wbyte;

    function automatic logic [3:0] prescale_top(input logic fast);
        prescale_top = fast ? `TCS_DIV_FAST - 4'd1 : `TCS_DIV_LEGACY - 4'd1;
    endfunction : prescale_top

    function automatic logic index_mapped(input logic [7:0] i);
        if ((i >= `TCS_IDX_TIMER0_LOW && i <= `TCS_IDX_CLK_STRETCH) || i == `TCS_IDX_PORT_ONE
            || i == `TCS_IDX_EXT_STATUS || i == `TCS_IDX_TIMED_ACCESS)
        begin
            index_mapped = 1'b1;
        end
        else
        begin
            index_mapped = 1'b0;
        end
    endfunction : index_mapped

    assign idx = paddr[9:2];
    assign wbyte = pwdata[7:0];
    assign access = psel & penable;
    assign setup_done = access & ~s_r.rdy;
    assign wr_acc = access & s_r.rdy & pwrite & ~s_r.err;

    always_comb
    begin
        logic tick0;
        logic tick1;
        logic [15:0] cnt0;
        logic [15:0] cnt1;
        tick0 = 1'b0;
        tick1 = 1'b0;
        cnt0 = {s_r.timer0_high_byte, s_r.timer0_low_byte};
        cnt1 = {s_r.timer1_high_byte, s_r.timer1_low_byte};
        s_nxt = s_r;
        s_nxt.ovf0 = 1'b0;
        s_nxt.ovf1 = 1'b0;

        if (timer0_run)
        begin
            if (s_r.pre0 >= prescale_top(s_r.clock_and_stretch_control[`TCS_BIT_T0M]))
            begin
                s_nxt.pre0 = 4'h0;
                tick0 = 1'b1;
            end
            else
            begin
                s_nxt.pre0 = s_r.pre0 + 4'h1;
            end
        end
        if (timer1_run)
        begin
            if (s_r.pre1 >= prescale_top(s_r.clock_and_stretch_control[`TCS_BIT_T1M]))
            begin
                s_nxt.pre1 = 4'h0;
                tick1 = 1'b1;
            end
            else
            begin
                s_nxt.pre1 = s_r.pre1 + 4'h1;
            end
        end
        if (tick0)
        begin
            {s_nxt.ovf0, s_nxt.timer0_high_byte, s_nxt.timer0_low_byte} = {1'b0, cnt0} + 17'h00001;
        end
        if (tick1)
        begin
            {s_nxt.ovf1, s_nxt.timer1_high_byte, s_nxt.timer1_low_byte} = {1'b0, cnt1} + 17'h00001;
        end

        s_nxt.rdy = setup_done;
        if (setup_done)
        begin
            s_nxt.err = ~index_mapped(idx) | (paddr[1:0] != 2'h0) | (paddr[11:10] != 2'h0);
            s_nxt.rdata = 32'h00000000;
            if (!pwrite && !s_nxt.err)
            begin
                if (idx == `TCS_IDX_TIMER0_LOW)
                begin
                    s_nxt.rdata[7:0] = s_r.timer0_low_byte;
                end
                else if (idx == `TCS_IDX_TIMER1_LOW)
                begin
                    s_nxt.rdata[7:0] = s_r.timer1_low_byte;
                end
                else if (idx == `TCS_IDX_TIMER0_HIGH)
                begin
                    s_nxt.rdata[7:0] = s_r.timer0_high_byte;
                end
                else if (idx == `TCS_IDX_TIMER1_HIGH)
                begin
                    s_nxt.rdata[7:0] = s_r.timer1_high_byte;
                end
                else if (idx == `TCS_IDX_CLK_STRETCH)
                begin
                    s_nxt.rdata[7:0] = s_r.clock_and_stretch_control;
                end
                else if (idx == `TCS_IDX_PORT_ONE)
                begin
                    s_nxt.rdata[7:0] = s_r.port_one;
                end
                else if (idx == `TCS_IDX_EXT_STATUS)
                begin
                    s_nxt.rdata[7:0] = {s_r.int_flags, 2'b00, resume_clock_select, s_r.bandgap_stop_select};
                end
                else
                begin
                    s_nxt.rdata[7:0] = {6'h00, s_r.ta_armed, s_r.ta_first};
                end
            end
        end
        else
        begin
            s_nxt.err = 1'b0;
        end

        if (wr_acc)
        begin
            s_nxt.ta_first = 1'b0;
            s_nxt.ta_armed = 1'b0;
            if (idx == `TCS_IDX_TIMER0_LOW)
            begin
                s_nxt.timer0_low_byte = wbyte;
            end
            else if (idx == `TCS_IDX_TIMER1_LOW)
            begin
                s_nxt.timer1_low_byte = wbyte;
            end
            else if (idx == `TCS_IDX_TIMER0_HIGH)
            begin
                s_nxt.timer0_high_byte = wbyte;
            end
            else if (idx == `TCS_IDX_TIMER1_HIGH)
            begin
                s_nxt.timer1_high_byte = wbyte;
            end
            else if (idx == `TCS_IDX_CLK_STRETCH)
            begin
                s_nxt.clock_and_stretch_control = wbyte;
            end
            else if (idx == `TCS_IDX_PORT_ONE)
            begin
                s_nxt.port_one = wbyte;
            end
            else if (idx == `TCS_IDX_EXT_STATUS)
            begin
                s_nxt.int_flags = wbyte[7:4];
                if (s_r.ta_armed)
                begin
                    s_nxt.bandgap_stop_select = wbyte[`TCS_BIT_BANDGAP_SEL];
                end
            end
            else
            begin
                s_nxt.ta_first = (wbyte == `TCS_TA_KEY_FIRST);
                s_nxt.ta_armed = s_r.ta_first & (wbyte == `TCS_TA_KEY_SECOND);
            end
        end
        s_nxt.int_flags = s_nxt.int_flags | ext_int_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r.timer0_low_byte <= `TCS_RST_TIMER_BYTE;
            s_r.timer0_high_byte <= `TCS_RST_TIMER_BYTE;
            s_r.timer1_low_byte <= `TCS_RST_TIMER_BYTE;
            s_r.timer1_high_byte <= `TCS_RST_TIMER_BYTE;
            s_r.clock_and_stretch_control <= `TCS_RST_CLK_STRETCH;
            s_r.port_one <= `TCS_RST_PORT_ONE;
            s_r.int_flags <= 4'h0;
            s_r.bandgap_stop_select <= 1'b0;
            s_r.pre0 <= 4'h0;
            s_r.pre1 <= 4'h0;
            s_r.ta_first <= 1'b0;
            s_r.ta_armed <= 1'b0;
            s_r.ovf0 <= 1'b0;
            s_r.ovf1 <= 1'b0;
            s_r.rdy <= 1'b0;
            s_r.err <= 1'b0;
            s_r.rdata <= 32'h00000000;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    tcs_stretch #(
        .MC_CLKS(MC_CLKS)
    ) u_stretch (
        .pclk(pclk),
        .presetn(presetn),
        .move_start(move_start),
        .move_external(move_external),
        .move_read(move_read),
        .stretch_field(s_r.clock_and_stretch_control[2:0]),
        .move_busy(move_busy),
        .ext_rd_strobe(ext_rd_strobe),
        .ext_wr_strobe(ext_wr_strobe),
        .move_done(move_done)
    );

    tcs_stop_ctl #(
        .HAS_RING(HAS_RING)
    ) u_stop (
        .pclk(pclk),
        .presetn(presetn),
        .por_n(por_n),
        .stop_req(stop_req),
        .wake_evt(wake_evt),
        .crystal_warm(crystal_warm),
        .resume_wr(wr_acc && (idx == `TCS_IDX_EXT_STATUS)),
        .resume_wdata(wbyte[`TCS_BIT_RESUME_SEL]),
        .bandgap_stop_select(s_r.bandgap_stop_select),
        .resume_clock_select(resume_clock_select),
        .core_halt(core_halt),
        .run_on_ring(run_on_ring),
        .bandgap_en(bandgap_en),
        .powerfail_en(powerfail_en)
    );

    assign prdata = s_r.rdata;
    assign pready = s_r.rdy;
    assign pslverr = s_r.err;
    assign timer0_overflow = s_r.ovf0;
    assign timer1_overflow = s_r.ovf1;
    assign timer2_clock_select = s_r.clock_and_stretch_control[`TCS_BIT_T2M];
    assign port_one_latch = s_r.port_one;

endmodule : tcs_bank

/* hdl/tcs_map.svh */
// Register indices, field positions, reset values and timing counts of the timer and clock-stop bank.
// Assumes a 250 MHz core clock and 32-bit APB words, one register per word at four times its index.
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH

`define TCS_IDX_TIMER0_LOW 8'h8a
`define TCS_IDX_TIMER1_LOW 8'h8b
`define TCS_IDX_TIMER0_HIGH 8'h8c
`define TCS_IDX_TIMER1_HIGH 8'h8d
`define TCS_IDX_CLK_STRETCH 8'h8e
`define TCS_IDX_PORT_ONE 8'h90
`define TCS_IDX_EXT_STATUS 8'h91
`define TCS_IDX_TIMED_ACCESS 8'h9f

`define TCS_RST_TIMER_BYTE 8'h00
`define TCS_RST_CLK_STRETCH 8'h01
`define TCS_RST_PORT_ONE 8'h01

`define TCS_BIT_T2M 5
`define TCS_BIT_T1M 4
`define TCS_BIT_T0M 3
`define TCS_BIT_RESUME_SEL 1
`define TCS_BIT_BANDGAP_SEL 0

`define TCS_TA_KEY_FIRST 8'haa
`define TCS_TA_KEY_SECOND 8'h55

`define TCS_DIV_LEGACY 4'd12
`define TCS_DIV_FAST 4'd4
`define TCS_MC_CLKS 4
`define TCS_MOVE_BASE_SHORT 4'd2
`define TCS_MOVE_BASE_LONG 4'd5

`endif

/* hdl/tcs_pkg.sv */
// Types shared by the timer and clock-stop bank.
// Assumes nothing beyond a SystemVerilog compiler.
package tcs_pkg;

    typedef enum logic [3:0] {
        TCS_PWR_RUN = 4'h1,
        TCS_PWR_STOP = 4'h2,
        TCS_PWR_WARM = 4'h4,
        TCS_PWR_RING = 4'h8
    } tcs_pwr_t;

    typedef enum logic [1:0] {
        TCS_MOVE_IDLE = 2'h1,
        TCS_MOVE_BUSY = 2'h2
    } tcs_move_t;

endpackage : tcs_pkg

/* hdl/tcs_stretch.sv */
// External data move sequencer that holds the read or write strobe for the selected stretch.
// Assumes move requests come from core logic on pclk and last one cycle.
`timescale 1ns/1ps
`include "tcs_map.svh"

module tcs_stretch #(
    parameter int MC_CLKS = `TCS_MC_CLKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic move_start,
    input wire logic move_external,
    input wire logic move_read,
    input wire logic [2:0] stretch_field,
    output logic move_busy,
    output logic ext_rd_strobe,
    output logic ext_wr_strobe,
    output logic move_done
);

    typedef struct packed {
        tcs_pkg::tcs_move_t st;
        logic [7:0] left;
        logic rd;
        logic wr;
        logic done;
    } tcs_str_t;

    tcs_str_t s_r;
    tcs_str_t s_nxt;

    function automatic logic [3:0] move_cycles(input logic [2:0] f);
        move_cycles = f[2] ? `TCS_MOVE_BASE_LONG + {1'b0, f} : `TCS_MOVE_BASE_SHORT + {1'b0, f};
    endfunction : move_cycles

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        case (s_r.st)
            tcs_pkg::TCS_MOVE_IDLE:
            begin
                if (move_start)
                begin
                    s_nxt.st = tcs_pkg::TCS_MOVE_BUSY;
                    if (move_external)
                    begin
                        s_nxt.left = 8'(move_cycles(stretch_field) * MC_CLKS - 1);
                        s_nxt.rd = move_read;
                        s_nxt.wr = ~move_read;
                    end
                    else
                    begin
                        s_nxt.left = 8'(`TCS_MOVE_BASE_SHORT * MC_CLKS - 1);
                    end
                end
            end
            tcs_pkg::TCS_MOVE_BUSY:
            begin
                if (s_r.left == 8'h00)
                begin
                    s_nxt.st = tcs_pkg::TCS_MOVE_IDLE;
                    s_nxt.rd = 1'b0;
                    s_nxt.wr = 1'b0;
                    s_nxt.done = 1'b1;
                end
                else
                begin
                    s_nxt.left = s_r.left - 8'h01;
                end
            end
            default:
            begin
                s_nxt.st = tcs_pkg::TCS_MOVE_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= '{st: tcs_pkg::TCS_MOVE_IDLE, left: 8'h00, rd: 1'b0, wr: 1'b0, done: 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign move_busy = (s_r.st == tcs_pkg::TCS_MOVE_BUSY);
    assign ext_rd_strobe = s_r.rd;
    assign ext_wr_strobe = s_r.wr;
    assign move_done = s_r.done;

endmodule : tcs_stretch

/* hdl/tcs_stop_ctl.sv */
// Stop mode sequencer: resume clock choice, crystal warm-up hold and band-gap enable.
// Assumes por_n is the power-on reset only and crystal_warm arrives from the oscillator asynchronously.
`timescale 1ns/1ps

module tcs_stop_ctl #(
    parameter bit HAS_RING = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    input wire logic stop_req,
    input wire logic wake_evt,
    input wire logic crystal_warm,
    input wire logic resume_wr,
    input wire logic resume_wdata,
    input wire logic bandgap_stop_select,
    output logic resume_clock_select,
    output logic core_halt,
    output logic run_on_ring,
    output logic bandgap_en,
    output logic powerfail_en
);

    typedef struct packed {
        tcs_pkg::tcs_pwr_t st;
        logic warm_m;
        logic warm_s;
        logic halt;
        logic ring;
        logic bg;
    } tcs_stop_t;

    tcs_stop_t s_r;
    tcs_stop_t s_nxt;
    logic resume_sel_r;

    always_ff @(posedge pclk or negedge por_n)
    begin
        if (!por_n)
        begin
            resume_sel_r <= 1'b0;
        end
        else if (resume_wr)
        begin
            resume_sel_r <= resume_wdata & HAS_RING;
        end
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.warm_m = crystal_warm;
        s_nxt.warm_s = s_r.warm_m;
        case (s_r.st)
            tcs_pkg::TCS_PWR_RUN:
            begin
                if (stop_req)
                begin
                    s_nxt.st = tcs_pkg::TCS_PWR_STOP;
                end
            end
            tcs_pkg::TCS_PWR_STOP:
            begin
                if (wake_evt)
                begin
                    s_nxt.st = resume_sel_r ? tcs_pkg::TCS_PWR_RING : tcs_pkg::TCS_PWR_WARM;
                end
            end
            tcs_pkg::TCS_PWR_WARM:
            begin
                if (s_r.warm_s)
                begin
                    s_nxt.st = tcs_pkg::TCS_PWR_RUN;
                end
            end
            tcs_pkg::TCS_PWR_RING:
            begin
                if (s_r.warm_s)
                begin
                    s_nxt.st = tcs_pkg::TCS_PWR_RUN;
                end
            end
            default:
            begin
                s_nxt.st = tcs_pkg::TCS_PWR_RUN;
            end
        endcase
        s_nxt.halt = (s_nxt.st == tcs_pkg::TCS_PWR_STOP) || (s_nxt.st == tcs_pkg::TCS_PWR_WARM);
        s_nxt.ring = (s_nxt.st == tcs_pkg::TCS_PWR_RING);
        s_nxt.bg = (s_nxt.st != tcs_pkg::TCS_PWR_STOP) || bandgap_stop_select;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= '{st: tcs_pkg::TCS_PWR_RUN, warm_m: 1'b0, warm_s: 1'b0, halt: 1'b0, ring: 1'b0, bg: 1'b1};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign resume_clock_select = resume_sel_r;
    assign core_halt = s_r.halt;
    assign run_on_ring = s_r.ring;
    assign bandgap_en = s_r.bg;
    assign powerfail_en = s_r.bg;

endmodule : tcs_stop_ctl

/* dv/tcs_bank_asserts.sv */
// Concurrent checks on the ports of the timer and clock-stop bank.
// Assumes it is bound to tcs_bank with the same machine cycle length.
`timescale 1ns/1ps
module tcs_bank_asserts #(
    parameter int MC_CLKS = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic move_start,
    input wire logic move_external,
    input wire logic move_read,
    input wire logic move_busy,
    input wire logic ext_rd_strobe,
    input wire logic ext_wr_strobe,
    input wire logic move_done,
    input wire logic crystal_warm,
    input wire logic core_halt,
    input wire logic run_on_ring,
    input wire logic bandgap_en,
    input wire logic powerfail_en
);
    localparam int T_LO = 2 * MC_CLKS - 1;
    localparam int T_HI = 2 * MC_CLKS;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_apb_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("late ready");
    property p_ext_rd;
        move_start && !move_busy && move_external && move_read |=> ext_rd_strobe && !ext_wr_strobe;
    endproperty
    a_ext_rd: assert property (p_ext_rd) else $error("no rd strobe");
    property p_ext_wr;
        move_start && !move_busy && move_external && !move_read |=> ext_wr_strobe && !ext_rd_strobe;
    endproperty
    a_ext_wr: assert property (p_ext_wr) else $error("no wr strobe");
    property p_int_len;
        move_start && !move_busy && !move_external |=> (!ext_rd_strobe && !ext_wr_strobe) ##[T_LO:T_HI] move_done;
    endproperty
    a_int_len: assert property (p_int_len) else $error("internal length");
    property p_strobe_hold;
        ext_rd_strobe |=> ext_rd_strobe || move_done;
    endproperty
    a_strobe_hold: assert property (p_strobe_hold) else $error("strobe drop");
    property p_warm_hold;
        core_halt && !crystal_warm && !$past(crystal_warm) && !$past(crystal_warm, 2) && !$past(crystal_warm, 3)
            |=> core_halt || run_on_ring;
    endproperty
    a_warm_hold: assert property (p_warm_hold) else $error("early resume");
    property p_ring_run;
        run_on_ring |-> !core_halt;
    endproperty
    a_ring_run: assert property (p_ring_run) else $error("ring halt");
    property p_bg_run;
        !core_halt && !run_on_ring |-> bandgap_en;
    endproperty
    a_bg_run: assert property (p_bg_run) else $error("reference off");
    property p_pf_off;
        !bandgap_en |-> !powerfail_en;
    endproperty
    a_pf_off: assert property (p_pf_off) else $error("power-fail on");
    c_ext: cover property (ext_wr_strobe ##1 move_done);
    c_ring: cover property (run_on_ring);
    c_stop_bg: cover property (core_halt && bandgap_en);
endmodule : tcs_bank_asserts
bind tcs_bank tcs_bank_asserts #(.MC_CLKS(MC_CLKS)) u_chk (.pclk, .presetn, .psel, .penable, .pready, .move_start,
    .move_external, .move_read, .move_busy, .ext_rd_strobe, .ext_wr_strobe, .move_done, .crystal_warm, .core_halt,
    .run_on_ring, .bandgap_en, .powerfail_en);

/* dv/tcs_ext_mem.sv */
// External memory stand-in that measures how long each strobe is held.
// Assumes active-high strobes on pclk.
`timescale 1ns/1ps
module tcs_ext_mem (
    input wire logic pclk,
    input wire logic ext_rd_strobe,
    input wire logic ext_wr_strobe,
    output int width
);
    int cnt = 0;
    initial width = 0;
    always @(posedge pclk)
    begin
        if (ext_rd_strobe || ext_wr_strobe)
            cnt <= cnt + 1;
        else if (cnt != 0)
        begin
            width <= cnt;
            cnt <= 0;
        end
    end
endmodule : tcs_ext_mem

/* dv/tcs_bank_test.sv */
// Self-checking bench for the timer and clock-stop bank.
// Assumes the external memory model and the bound checker.
`timescale 1ns/1ps
`include "tcs_map.svh"
module tcs_bank_test;
    localparam int MC = 4;
    logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, timer0_run = 0, move_start = 0, move_external = 0, move_read = 0;
    logic stop_req = 0, wake_evt = 0, crystal_warm = 0, timer0_overflow, timer2_clock_select;
    logic move_busy, ext_rd_strobe, ext_wr_strobe, move_done, core_halt, run_on_ring, bandgap_en, powerfail_en;
    int err_count = 0, checks = 0, cyc = 0, lat, base_w, base_l, wid;
    logic [7:0] ix [6] = '{`TCS_IDX_TIMER0_LOW, `TCS_IDX_TIMER1_LOW, `TCS_IDX_TIMER0_HIGH, `TCS_IDX_TIMER1_HIGH,
        `TCS_IDX_CLK_STRETCH, `TCS_IDX_PORT_ONE};
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, `TCS_RST_CLK_STRETCH, `TCS_RST_PORT_ONE};
    int dur [8] = '{2, 3, 4, 5, 9, 10, 11, 12};
    tcs_bank #(.MC_CLKS(MC)) uut (.pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .timer0_run, .timer1_run(timer0_run), .ext_int_set(4'h0), .move_start, .move_external,
        .move_read, .stop_req, .wake_evt, .crystal_warm, .timer0_overflow, .timer1_overflow(), .timer2_clock_select,
        .port_one_latch(), .move_busy, .ext_rd_strobe, .ext_wr_strobe, .move_done, .core_halt, .run_on_ring,
        .bandgap_en, .powerfail_en);
    tcs_ext_mem mem (.pclk, .ext_rd_strobe, .ext_wr_strobe, .width(wid));
    initial forever #2 pclk = ~pclk;
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    always @(posedge pclk)
    begin
        if (++cyc >= 20000)
        begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rc(input string n, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, '0);
        chk(n, rd, exp);
    endtask : rc
    task automatic mv(input logic e, input logic r);
        @(posedge pclk);
        move_start <= 1'b1;
        move_external <= e;
        move_read <= r;
        @(posedge pclk);
        move_start <= 1'b0;
        for (lat = 1; move_done !== 1'b1 && lat < 200; lat++)
            @(posedge pclk);
        repeat (2) @(posedge pclk);
    endtask : mv
    task automatic sw(input logic bgx);
        @(posedge pclk);
        stop_req <= 1'b1;
        @(posedge pclk);
        stop_req <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("halt", core_halt, 1'b1);
        chk("bandgap", bandgap_en, bgx);
        chk("powerfail", powerfail_en, bgx);
        wake_evt <= 1'b1;
        @(posedge pclk);
        wake_evt <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : sw
    task automatic warm;
        crystal_warm <= 1'b1;
        repeat (6) @(posedge pclk);
        crystal_warm <= 1'b0;
    endtask : warm
    task automatic tm(input logic [7:0] ck, input logic slow);
        apb(1'b1, `TCS_IDX_CLK_STRETCH, {24'h0, ck});
        apb(1'b1, `TCS_IDX_TIMER0_LOW, 32'hfe);
        apb(1'b1, `TCS_IDX_TIMER0_HIGH, 32'hff);
        timer0_run <= 1'b1;
        for (lat = 0; timer0_overflow !== 1'b1 && lat < 200; lat++)
            @(posedge pclk);
        timer0_run <= 1'b0;
        chk("timer rate", lat > 10, slow);
    endtask : tm
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        for (int i = 0; i < 6; i++)
            rc("reset value", ix[i], rv[i]);
        rc("status reset", `TCS_IDX_EXT_STATUS, 0);
        apb(1'b1, `TCS_IDX_TIMER0_HIGH, 32'hffff_ffa5);
        apb(1'b1, `TCS_IDX_TIMER1_HIGH, 32'h5a);
        rc("timer0 high", `TCS_IDX_TIMER0_HIGH, 32'ha5);
        rc("timer1 high", `TCS_IDX_TIMER1_HIGH, 32'h5a);
        apb(1'b0, 8'h92, 0);
        chk("unmapped error", er, 1'b1);
        chk("unmapped data", rd, 0);
        $display("register test done");
        for (int s = 0; s < 8; s++)
        begin
            apb(1'b1, `TCS_IDX_CLK_STRETCH, s);
            mv(1'b1, s[0]);
            if (s == 0)
            begin
                base_w = wid;
                base_l = lat;
            end
            chk("stretch width", wid - base_w, (dur[s] - 2) * MC);
        end
        mv(1'b0, 1'b0);
        chk("internal latency", lat, base_l);
        apb(1'b1, `TCS_IDX_CLK_STRETCH, 0);
        fork
            mv(1'b1, 1'b1);
            begin
                repeat (2) @(posedge pclk);
                apb(1'b1, `TCS_IDX_CLK_STRETCH, 7);
            end
        join
        chk("width in flight", wid, base_w);
        mv(1'b1, 1'b0);
        chk("width after change", wid - base_w, 10 * MC);
        $display("move test done");
        sw(1'b0);
        chk("warm hold", core_halt, 1'b1);
        chk("no ring", run_on_ring, 1'b0);
        warm();
        chk("resumed", core_halt, 1'b0);
        apb(1'b1, `TCS_IDX_EXT_STATUS, 32'h03);
        rc("locked bandgap", `TCS_IDX_EXT_STATUS, 32'h02);
        sw(1'b0);
        chk("ring run", run_on_ring, 1'b1);
        chk("ring halt", core_halt, 1'b0);
        warm();
        chk("crystal back", run_on_ring, 1'b0);
        apb(1'b1, `TCS_IDX_TIMED_ACCESS, `TCS_TA_KEY_FIRST);
        apb(1'b1, `TCS_IDX_TIMED_ACCESS, `TCS_TA_KEY_SECOND);
        apb(1'b1, `TCS_IDX_EXT_STATUS, 32'h03);
        rc("unlocked bandgap", `TCS_IDX_EXT_STATUS, 32'h03);
        sw(1'b1);
        warm();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rc("warm reset", `TCS_IDX_EXT_STATUS, 32'h02);
        presetn <= 1'b0;
        por_n <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        rc("power-on reset", `TCS_IDX_EXT_STATUS, 0);
        $display("stop test done");
        tm(8'h01, 1'b1);
        tm(8'h09, 1'b0);
        apb(1'b1, `TCS_IDX_CLK_STRETCH, 32'h21);
        @(posedge pclk);
        chk("timer2 select", timer2_clock_select, 1'b1);
        $display("timer test done");
        tally_and_finish();
    end
endmodule : tcs_bank_test
